// >>> bench/lcd_panel_model.sv
// panel model: counts the electrodes that the lcd side drives
`default_nettype none

module lcd_panel_model (
  // pin functions from the block
  input wire logic [7:0] com_func,
  input wire logic [31:0] seg_func,
  // electrodes the panel sees driven by lcd waveforms
  output logic [3:0] com_seen,
  output logic [5:0] seg_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  // a pin left to gpio is not an electrode drive, so only set bits count
  assign com_seen = 4'($countones(com_func));
  assign seg_seen = 6'($countones(seg_func));
endmodule

`default_nettype wire

// >>> bench/tb_lcd_pin_function_select.sv
// testbench for the lcd pin function select block
`default_nettype none

module tb_lcd_pin_function_select;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic gpio_enable;
  logic [7:0] com_func;
  logic [31:0] seg_func;
  logic [3:0] com_seen;
  logic [5:0] seg_seen;
  logic [31:0] rd;
  logic [31:0] seg_all;
  logic [7:0] segv [4] = '{8'h81, 8'h3c, 8'h5a, 8'hf0};
  int miscompares = 0;
  int check_count = 0;

  always #12.5 hclk = ~hclk;

  lcd_pin_function_select u_lcd_pin_function_select (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .com_func(com_func), .seg_func(seg_func), .gpio_enable(gpio_enable));
  lcd_panel_model u_lcd_panel_model (.com_func(com_func), .seg_func(seg_func),
    .com_seen(com_seen), .seg_seen(seg_seen));

  function automatic logic [31:0] adr(input logic [11:0] idx);
    return {18'h0, idx, 2'b00};
  endfunction

  // one single transfer; hsel stays high so no signal is driven twice per step
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= lcd_pin_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    bus(adr(idx), 1'b1, d);
  endtask

  task automatic chk_reg(input string what, input logic [11:0] idx, input logic [31:0] exp);
    bus(adr(idx), 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask

  // pins settle at the edge that ends the write, so look 1 ns later
  task automatic chk_pins(input logic [7:0] com, input logic [31:0] seg, input logic gpio);
    #1;
    chk("com_func", {24'h0, com}, {24'h0, com_func});
    chk("seg_func", seg, seg_func);
    chk("gpio_enable", {31'h0, gpio}, {31'h0, gpio_enable});
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    chk("com_seen", 32'($countones(com)), {28'h0, com_seen});
    chk("seg_seen", 32'($countones(seg)), {26'h0, seg_seen});
    @(posedge hclk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    seg_all = {segv[3], segv[2], segv[1], segv[0]};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_pins(8'h00, 32'hffff_ffff, 1'b0);
    chk_reg("control", lcd_pin_pkg::IDX_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      chk_reg("seg_sel_rst", lcd_pin_pkg::IDX_SEG_0_7 + 12'(i), 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(lcd_pin_pkg::IDX_SEG_0_7 + 12'(i), {24'h0, segv[i]});
    end
    // selects are held but port input control is still off
    chk_pins(8'h00, 32'hffff_ffff, 1'b0);
    for (int i = 0; i < 4; i++) begin
      chk_reg("seg_sel", lcd_pin_pkg::IDX_SEG_0_7 + 12'(i), {24'h0, segv[i]});
    end
    // aliased address outside the map must not reach the first select
    bus(32'h0000_4000 | adr(lcd_pin_pkg::IDX_SEG_0_7), 1'b1, 32'h0000_00ff);
    chk_reg("seg_sel_alias", lcd_pin_pkg::IDX_SEG_0_7, {24'h0, segv[0]});
    wr(lcd_pin_pkg::IDX_COM_SEL, 32'h0000_00a5);
    for (int m = 0; m < 8; m++) begin
      wr(lcd_pin_pkg::IDX_CTRL, {24'h0, 1'b1, 2'b00, 3'(m), 2'b00});
      chk_pins((m >= 4) ? 8'ha5 : 8'h05, seg_all, 1'b1);
      chk_reg("control", lcd_pin_pkg::IDX_CTRL, {24'h0, 1'b1, 2'b00, 3'(m), 2'b00});
      chk_reg("com_func_reg", lcd_pin_pkg::IDX_COM_FUNC, (m >= 4) ? 32'h0000_00a5 : 32'h0000_0005);
    end
    chk_reg("seg_func_reg", lcd_pin_pkg::IDX_SEG_FUNC, seg_all);
    chk_reg("com_sel", lcd_pin_pkg::IDX_COM_SEL, 32'h0000_00a5);
    wr(lcd_pin_pkg::IDX_CTRL, 32'h0000_0010);
    chk_pins(8'ha5, 32'hffff_ffff, 1'b0);
    chk_reg("seg_func_off", lcd_pin_pkg::IDX_SEG_FUNC, 32'hffff_ffff);
    report_and_stop;
  end
endmodule

`default_nettype wire

// >>> rtl/lcd_pin_function_select.sv
// lcd common and segment pin function select with ahb-lite registers
//
// The AHB-Lite interface to the registers was decided locally.
`default_nettype none

module lcd_pin_function_select #(
  parameter int COM_COUNT = 8,
  parameter int SEG_COUNT = 32
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pin functions, 1 = lcd waveform, 0 = general-purpose i/o
  output logic [7:0] com_func,
  output logic [31:0] seg_func,
  // shared gpio enable
  output logic gpio_enable
);

  // the register map is fixed, so other pin counts are refused at elaboration
  if ((COM_COUNT != lcd_pin_pkg::COM_PINS) ||
      (SEG_COUNT != lcd_pin_pkg::SEG_PINS)) begin : g_bad_size
    $error("lcd_pin_function_select: only 8 commons and 32 segments are served");
  end

  typedef struct packed {
    logic pic;
    logic [2:0] mode;
    logic [7:0] com_sel;
    logic [31:0] seg_sel;
    logic wr_pend;
    logic rd_pend;
    logic [11:0] dp_idx;
    logic [31:0] rdata;
    logic hreadyout;
    logic [7:0] com_func;
    logic [31:0] seg_func;
    logic gpio_en;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic addr_ok;
  logic [11:0] ap_idx;
  logic take;
  logic eight_mode_d;
  logic [3:0] com_hi_d;
  logic [31:0] seg_gated_d;

  // address decode: only word slots in the low block are mapped
  assign ap_idx = haddr[lcd_pin_pkg::IDX_MSB:lcd_pin_pkg::IDX_LSB];
  assign addr_ok = (haddr[31:lcd_pin_pkg::IDX_MSB+1] == 18'h0_0000) && (haddr[1:0] == 2'h0);
  assign take = hsel && hready && (htrans == lcd_pin_pkg::HTRANS_NONSEQ) && addr_ok;

  // mode decode uses the next mode so pins change at the same edge as the register
  assign eight_mode_d = (st_d.mode >= lcd_pin_pkg::MODE_EIGHT_MIN);

  pin_func_gate #(
    .WIDTH(4)
  ) u_com_hi (
    .sel(st_d.com_sel[7:4]),
    .allow(eight_mode_d),
    .fallback(4'h0),
    .func(com_hi_d)
  );

  // segment groups: with port input off the gpio side is dead, so pins stay lcd
  for (genvar g = 0; g < lcd_pin_pkg::SEG_PINS / lcd_pin_pkg::SEG_GROUP; g++) begin : g_seg
    pin_func_gate #(
      .WIDTH(lcd_pin_pkg::SEG_GROUP)
    ) u_seg (
      .sel(st_d.seg_sel[g*8 +: 8]),
      .allow(st_d.pic),
      .fallback(8'hff),
      .func(seg_gated_d[g*8 +: 8])
    );
  end

  always_comb begin
    st_d = st_q;
    st_d.hreadyout = 1'b1;
    // data phase of a write lands here
    if (st_q.wr_pend) begin
      case (st_q.dp_idx)
        lcd_pin_pkg::IDX_CTRL: begin
          st_d.pic = hwdata[lcd_pin_pkg::CTRL_PIC_BIT];
          st_d.mode = hwdata[lcd_pin_pkg::CTRL_MODE_MSB:lcd_pin_pkg::CTRL_MODE_LSB];
        end
        lcd_pin_pkg::IDX_COM_SEL: begin
          st_d.com_sel = hwdata[7:0];
        end
        lcd_pin_pkg::IDX_SEG_0_7: begin
          st_d.seg_sel[7:0] = hwdata[7:0];
        end
        lcd_pin_pkg::IDX_SEG_8_15: begin
          st_d.seg_sel[15:8] = hwdata[7:0];
        end
        lcd_pin_pkg::IDX_SEG_16_23: begin
          st_d.seg_sel[23:16] = hwdata[7:0];
        end
        lcd_pin_pkg::IDX_SEG_24_31: begin
          st_d.seg_sel[31:24] = hwdata[7:0];
        end
        default: begin
          // unmapped or read-only slot: write dropped
        end
      endcase
    end
    // address phase
    st_d.wr_pend = take && hwrite;
    st_d.rd_pend = take && !hwrite;
    st_d.dp_idx = take ? ap_idx : 12'h000;
    // effective functions, taken from the next register state
    st_d.com_func = {com_hi_d, st_d.com_sel[3:0]};
    st_d.seg_func = seg_gated_d;
    st_d.gpio_en = st_d.pic;
    // read data is built from the next state, so a write just before is seen
    st_d.rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      case (ap_idx)
        lcd_pin_pkg::IDX_CTRL: begin
          st_d.rdata[lcd_pin_pkg::CTRL_PIC_BIT] = st_d.pic;
          st_d.rdata[lcd_pin_pkg::CTRL_MODE_MSB:lcd_pin_pkg::CTRL_MODE_LSB] = st_d.mode;
        end
        lcd_pin_pkg::IDX_COM_SEL: begin
          st_d.rdata[7:0] = st_d.com_sel;
        end
        lcd_pin_pkg::IDX_SEG_0_7: begin
          st_d.rdata[7:0] = st_d.seg_sel[7:0];
        end
        lcd_pin_pkg::IDX_SEG_8_15: begin
          st_d.rdata[7:0] = st_d.seg_sel[15:8];
        end
        lcd_pin_pkg::IDX_SEG_16_23: begin
          st_d.rdata[7:0] = st_d.seg_sel[23:16];
        end
        lcd_pin_pkg::IDX_SEG_24_31: begin
          st_d.rdata[7:0] = st_d.seg_sel[31:24];
        end
        lcd_pin_pkg::IDX_COM_FUNC: begin
          st_d.rdata[7:0] = st_d.com_func;
        end
        lcd_pin_pkg::IDX_SEG_FUNC: begin
          st_d.rdata = st_d.seg_func;
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q.pic <= lcd_pin_pkg::PIC_RST;
      st_q.mode <= lcd_pin_pkg::MODE_RST;
      st_q.com_sel <= lcd_pin_pkg::COM_SEL_RST;
      st_q.seg_sel <= lcd_pin_pkg::SEG_SEL_RST;
      st_q.wr_pend <= 1'b0;
      st_q.rd_pend <= 1'b0;
      st_q.dp_idx <= 12'h000;
      st_q.rdata <= 32'h0000_0000;
      st_q.hreadyout <= 1'b1;
      st_q.com_func <= lcd_pin_pkg::COM_FUNC_RST;
      st_q.seg_func <= lcd_pin_pkg::SEG_FUNC_RST;
      st_q.gpio_en <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata = st_q.rdata;
  assign hreadyout = st_q.hreadyout;
  assign hresp = lcd_pin_pkg::HRESP_OKAY;
  assign com_func = st_q.com_func;
  assign seg_func = st_q.seg_func;
  assign gpio_enable = st_q.gpio_en;

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic eight_mode_q;
  assign eight_mode_q = (st_q.mode >= lcd_pin_pkg::MODE_EIGHT_MIN);

  // the segment slots are four aligned indices, so the low index bits pick the byte
  logic [7:0] seg_byte_q;
  assign seg_byte_q = st_q.seg_sel[ap_idx[1:0] * 8 +: 8];
  logic seg_slot_ap;
  assign seg_slot_ap = (ap_idx >= lcd_pin_pkg::IDX_SEG_0_7) && (ap_idx <= lcd_pin_pkg::IDX_SEG_24_31);
  logic seg_slot_dp;
  assign seg_slot_dp = (st_q.dp_idx >= lcd_pin_pkg::IDX_SEG_0_7)
    && (st_q.dp_idx <= lcd_pin_pkg::IDX_SEG_24_31);

  a_upper_com_eight: assert property (
    eight_mode_q |-> com_func[7:4] == st_q.com_sel[7:4])
    else $error("upper commons do not follow select in eight-common mode");

  a_upper_com_four: assert property (
    !eight_mode_q |-> com_func[7:4] == 4'h0)
    else $error("upper commons driven in four-common mode");

  a_lower_com_sel: assert property (
    com_func[3:0] == st_q.com_sel[3:0])
    else $error("lower commons do not follow select");

  a_seg_follow_sel: assert property (
    st_q.pic |-> seg_func == st_q.seg_sel)
    else $error("segment pins do not follow select");

  a_seg_write_map: assert property (
    st_q.wr_pend && (st_q.dp_idx >= lcd_pin_pkg::IDX_SEG_0_7)
      && (st_q.dp_idx <= lcd_pin_pkg::IDX_SEG_24_31)
    |=> st_q.seg_sel[($past(st_q.dp_idx) - lcd_pin_pkg::IDX_SEG_0_7) * 8 +: 8]
        == $past(hwdata[7:0]))
    else $error("segment select write landed in the wrong byte");

  a_seg_readback: assert property (
    take && !hwrite && (ap_idx == lcd_pin_pkg::IDX_SEG_8_15) && !st_q.wr_pend
    |=> hrdata == {24'h00_0000, $past(st_q.seg_sel[15:8])})
    else $error("segment select read back differs from stored value");

  a_seg_ignored: assert property (
    !st_q.pic |-> seg_func == 32'hffff_ffff)
    else $error("segment selects acted with port input off");

  a_mode_gate: assert property (
    $changed(st_q.mode) && (st_q.com_sel[7:4] != 4'h0)
    |-> com_func[7:4] == (eight_mode_q ? st_q.com_sel[7:4] : 4'h0))
    else $error("mode change did not regate upper commons");

  a_pic_gpio: assert property (
    st_q.wr_pend && (st_q.dp_idx == lcd_pin_pkg::IDX_CTRL)
    |=> gpio_enable == $past(hwdata[lcd_pin_pkg::CTRL_PIC_BIT]))
    else $error("gpio enable does not follow port input control");

  a_ctrl_hold: assert property (
    !(st_q.wr_pend && (st_q.dp_idx == lcd_pin_pkg::IDX_CTRL))
    |=> $stable(gpio_enable) && $stable(st_q.mode))
    else $error("control changed without a control write");

  a_mode_write_land: assert property (
    st_q.wr_pend && (st_q.dp_idx == lcd_pin_pkg::IDX_CTRL)
    |=> st_q.mode == $past(hwdata[lcd_pin_pkg::CTRL_MODE_MSB:lcd_pin_pkg::CTRL_MODE_LSB]))
    else $error("display mode write did not land");

  a_com_write_land: assert property (
    st_q.wr_pend && (st_q.dp_idx == lcd_pin_pkg::IDX_COM_SEL)
    |=> st_q.com_sel == $past(hwdata[7:0]))
    else $error("common select write did not land");

  a_com_sel_hold: assert property (
    !(st_q.wr_pend && (st_q.dp_idx == lcd_pin_pkg::IDX_COM_SEL))
    |=> $stable(st_q.com_sel))
    else $error("common select changed without a write");

  a_seg_sel_hold: assert property (
    !(st_q.wr_pend && seg_slot_dp) |=> $stable(st_q.seg_sel))
    else $error("segment selects changed without a write");

  a_seg_write_keep: assert property (
    st_q.wr_pend && (st_q.dp_idx == lcd_pin_pkg::IDX_SEG_0_7)
    |=> st_q.seg_sel[31:8] == $past(st_q.seg_sel[31:8]))
    else $error("segment select write touched other bytes");

  a_seg_read_any: assert property (
    take && !hwrite && seg_slot_ap && !st_q.wr_pend
    |=> hrdata == {24'h00_0000, $past(seg_byte_q)})
    else $error("segment select read returned another byte");

  a_ctrl_readback: assert property (
    take && !hwrite && (ap_idx == lcd_pin_pkg::IDX_CTRL) && !st_q.wr_pend
    |=> hrdata == {24'h00_0000, $past(st_q.pic), 2'b00, $past(st_q.mode), 2'b00})
    else $error("control read back differs from stored value");

  a_com_func_read: assert property (
    take && !hwrite && (ap_idx == lcd_pin_pkg::IDX_COM_FUNC) && !st_q.wr_pend
    |=> hrdata == {24'h00_0000, $past(com_func)})
    else $error("common function read differs from pins");

  a_seg_func_read: assert property (
    take && !hwrite && (ap_idx == lcd_pin_pkg::IDX_SEG_FUNC) && !st_q.wr_pend
    |=> hrdata == $past(seg_func))
    else $error("segment function read differs from pins");

  a_unmapped_drop: assert property (
    hsel && hready && (htrans == lcd_pin_pkg::HTRANS_NONSEQ) && !addr_ok
    |=> !st_q.wr_pend && !st_q.rd_pend)
    else $error("unmapped access was taken");

  // read data is zero outside its data phase, so a stale value never leaks
  a_rdata_idle: assert property (
    !st_q.rd_pend |-> hrdata == 32'h0000_0000)
    else $error("read data stands outside a read data phase");

  c_seg_write: cover property (
    st_q.wr_pend && st_q.dp_idx == lcd_pin_pkg::IDX_SEG_24_31 ##1 st_q.pic);
  c_eight_mode: cover property (eight_mode_q && com_func[7:4] != 4'h0);
  c_back_to_back: cover property (st_q.wr_pend && take && !hwrite);
  c_four_hidden: cover property (!eight_mode_q && st_q.com_sel[7:4] != 4'h0);
  c_pic_off_held: cover property (!st_q.pic && st_q.seg_sel != 32'h0000_0000);

endmodule

`default_nettype wire

// >>> rtl/lcd_pin_pkg.sv
// constants for the lcd pin function select block
// Operation
// - eight-common mode: upper common bits pick function
// - four-common mode: upper common bits do nothing
// - lower common bits pick function in both modes
// - segment bit: 0 gpio, 1 segment output
// - segment selects at 0fb4..0fb7, low segment bit0
// - segment selects read back written value, reset zero
// - segment selects act only while port input set
// - display mode field picks four or eight commons
// - port input control enables shared gpio, resets 0
`default_nettype none

package lcd_pin_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL = 12'hfb2;
  localparam logic [11:0] IDX_COM_SEL = 12'hfb3;
  localparam logic [11:0] IDX_SEG_0_7 = 12'hfb4;
  localparam logic [11:0] IDX_SEG_8_15 = 12'hfb5;
  localparam logic [11:0] IDX_SEG_16_23 = 12'hfb6;
  localparam logic [11:0] IDX_SEG_24_31 = 12'hfb7;
  localparam logic [11:0] IDX_COM_FUNC = 12'hfc0;
  localparam logic [11:0] IDX_SEG_FUNC = 12'hfc1;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 13;

  // control register field positions
  localparam int CTRL_PIC_BIT = 7;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_MODE_MSB = 4;

  // reset values
  localparam logic [7:0] COM_SEL_RST = 8'h00;
  localparam logic [31:0] SEG_SEL_RST = 32'h0000_0000;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic PIC_RST = 1'b0;
  // port input off after reset, so every segment pin sits on the lcd side
  localparam logic [7:0] COM_FUNC_RST = 8'h00;
  localparam logic [31:0] SEG_FUNC_RST = 32'hffff_ffff;

  // display mode codes: 0 stopped, 1..3 four-common duties, 4..7 eight-common duties
  localparam logic [2:0] MODE_STOP = 3'h0;
  localparam logic [2:0] MODE_EIGHT_MIN = 3'h4;

  // pin counts
  localparam int COM_PINS = 8;
  localparam int COM_LOW_PINS = 4;
  localparam int SEG_PINS = 32;
  localparam int SEG_GROUP = 8;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

`default_nettype wire

// >>> rtl/pin_func_gate.sv
// gate that passes a group of select bits or a fallback pattern
`default_nettype none

module pin_func_gate #(
  parameter int WIDTH = 8
) (
  // selection
  input wire logic [WIDTH-1:0] sel,
  input wire logic allow,
  input wire logic [WIDTH-1:0] fallback,
  // result, 1 means the lcd function owns the pin
  output logic [WIDTH-1:0] func
);

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_func_gate: WIDTH must be at least 1");
  end

  assign func = allow ? sel : fallback;

endmodule

`default_nettype wire
